// ---- logic/rcl_pkg.sv ----
package rcl_pkg;
    localparam int NCH   = 7;
    localparam int NBUCK = 3;
    localparam int NLIN  = 4;

    // byte offsets; channel index sits in paddr[6:4]
    localparam logic [7:0] OFS_PRI  = 8'h00;
    localparam logic [7:0] OFS_ALT  = 8'h04;
    localparam logic [7:0] OFS_CTL  = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h80;
    localparam int         CH_LSB   = 4;

    // control register fields
    localparam int CTL_ON     = 0;
    localparam int CTL_DLY    = 1;
    localparam int CTL_MODE   = 4;
    localparam int CTL_PD     = 5;
    localparam int CTL_UNMASK = 6;

    // status register fields
    localparam int ST_OK  = 0;
    localparam int ST_ON  = 8;
    localparam int ST_FLT = 16;
    localparam int ST_IRQ = 23;

    // power-up level codes per channel, values arbitrary
    localparam logic [5:0] DEF_CODE [NCH] = '{6'h1a, 6'h22, 6'h2c, 6'h31, 6'h39, 6'h24, 6'h14};

    // turn-on delay step; field value times step
    localparam int DELAY_STEP_NS  = 1000;
    localparam int LINK_PERIOD_NS = 160;
    localparam int DELAY_STEP_CYC = (DELAY_STEP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

    typedef struct packed {
        logic [5:0] pri;
        logic [5:0] alt;
        logic       on;
        logic [2:0] dly;
        logic       mode;
        logic       pd;
        logic       unmask;
    } rcl_cfg_s;

    typedef enum {LK_OFF, LK_WAIT, LK_ON} rcl_lk_e;
endpackage : rcl_pkg

// ---- logic/rcl_regulator_ctrl.sv ----
// Functional notes
// RULE1: channels start at built-in default codes
// RULE2: buck uses alternate code while pin high
// RULE3: host writes code matching current pin
// RULE4: six-bit code, row/column map 0.6-3.9 V
// RULE5: linear channel has single code register
// RULE6: enable bit acts on edges only
// RULE7: host writes 0 then 1, or 1 then 0
// RULE8: three-bit turn-on delay per channel
// RULE9: buck forced PWM when mode bit set
// RULE10: buck good bit low below threshold
// RULE11: linear good bit low below threshold
// RULE12: unmasked fault drives interrupt low
// RULE13: interrupt holds until recovered and read
// RULE14: linear pulldown only while disabled; code keeps it on for one link clock after the channel turns on
// RULE15: linear low quiescent bit per channel
// RULE16: registers reached through the slave port
// RULE17: write edge compare makes on/off pulse
// RULE18: status read needed to clear fault
`timescale 1ns/1ps
`default_nettype none
module rcl_regulator_ctrl
    import rcl_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  seq_clk,
    input  wire logic                  seq_rst_n,
    input  wire logic                  voltage_choice_pin,
    input  wire logic [NCH-1:0]        power_ok_in,
    output logic      [NCH-1:0]        supply_channel_on,
    output logic      [NLIN-1:0]       pulldown_enable,
    output logic      [NCH-1:0][5:0]   level_code,
    output logic      [NCH-1:0][11:0]  level_mv,
    output logic      [NBUCK-1:0]      fpwm_mode,
    output logic      [NLIN-1:0]       low_quiescent_bit,
    output logic                       interrupt_request_n
);
    function automatic logic [11:0] code_to_mv(input logic [5:0] c);
        logic [11:0] base;
        logic [11:0] step;
        base = 12'h000;
        step = 12'h000;
        case (c[2:0])
            3'h0: begin base = 12'd600;  step = 12'd25;  end
            3'h1: begin base = 12'd800;  step = 12'd25;  end
            3'h2: begin base = 12'd1000; step = 12'd25;  end
            3'h3: begin base = 12'd1200; step = 12'd50;  end
            3'h4: begin base = 12'd1600; step = 12'd50;  end
            3'h5: begin base = 12'd2000; step = 12'd50;  end
            3'h6: begin base = 12'd2400; step = 12'd100; end
            default: begin base = 12'd3200; step = 12'd100; end
        endcase
        return 12'(base + step * {9'h000, c[5:3]}); // RULE4
    endfunction : code_to_mv

    rcl_cfg_s       cfg [NCH];
    logic [2:0]     launch_dly [NCH];
    logic [NCH-1:0] on_tgl;
    logic [NCH-1:0] off_tgl;
    logic [NCH-1:0] fault;
    logic [NCH-1:0] read_seen;
    logic [1:0]     pin_sync;
    logic [NCH-1:0] ok_meta;
    logic [NCH-1:0] ok_s;
    logic [NCH-1:0] on_meta;
    logic [NCH-1:0] on_s;

    logic           acc;
    logic           wr;
    logic           rd;
    logic [2:0]     ch;
    logic [7:0]     ofs;
    logic           ch_hit;
    logic           stat_rd;
    logic [31:0]    next_prdata;
    logic           next_err;

    assign pready = 1'b1; // RULE16
    assign acc    = psel & penable;
    assign wr     = acc & pwrite;
    assign rd     = acc & ~pwrite;
    assign ch     = paddr[CH_LSB+2:CH_LSB];
    assign ofs    = {4'h0, paddr[3:0]};
    assign ch_hit = ~paddr[7] & (ch < 3'(NCH));
    assign stat_rd = rd & (paddr == OFS_STAT); // RULE18

    // pin and comparator levels come from outside the clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync <= 2'b00;
            ok_meta  <= '0;
            ok_s     <= '0;
            on_meta  <= '0;
            on_s     <= '0;
        end else begin
            pin_sync <= {pin_sync[0], voltage_choice_pin};
            ok_meta  <= power_ok_in;
            ok_s     <= ok_meta;
            on_meta  <= supply_channel_on;
            on_s     <= on_meta;
        end
    end

    // decode; alternate code exists on bucks only
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_err    = 1'b0;
        if (paddr == OFS_STAT) begin
            next_prdata[ST_OK +: NCH]  = ok_s; // RULE10 RULE11
            next_prdata[ST_ON +: NCH]  = on_s;
            next_prdata[ST_FLT +: NCH] = fault;
            next_prdata[ST_IRQ]        = |fault;
        end else if (ch_hit && ofs == OFS_PRI) begin
            next_prdata[5:0] = cfg[ch].pri;
        end else if (ch_hit && ofs == OFS_ALT && ch < 3'(NBUCK)) begin
            next_prdata[5:0] = cfg[ch].alt;
        end else if (ch_hit && ofs == OFS_CTL) begin
            next_prdata[CTL_ON]       = cfg[ch].on;
            next_prdata[CTL_DLY +: 3] = cfg[ch].dly;
            next_prdata[CTL_MODE]     = cfg[ch].mode;
            next_prdata[CTL_PD]       = cfg[ch].pd;
            next_prdata[CTL_UNMASK]   = cfg[ch].unmask;
        end else begin
            next_err = 1'b1;
        end
    end

    assign prdata  = rd ? next_prdata : 32'h0000_0000;
    assign pslverr = acc & next_err;

    // configuration registers; writes land at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                cfg[i] <= '{pri: DEF_CODE[i], alt: DEF_CODE[i], default: '0}; // RULE1
            end
        end else if (wr && ch_hit) begin
            if (ofs == OFS_PRI) begin
                cfg[ch].pri <= pwdata[5:0]; // RULE5
            end else if (ofs == OFS_ALT && ch < 3'(NBUCK)) begin
                cfg[ch].alt <= pwdata[5:0];
            end else if (ofs == OFS_CTL) begin
                cfg[ch].on     <= pwdata[CTL_ON];
                cfg[ch].dly    <= pwdata[CTL_DLY +: 3]; // RULE8
                cfg[ch].mode   <= pwdata[CTL_MODE];
                cfg[ch].pd     <= pwdata[CTL_PD];
                cfg[ch].unmask <= pwdata[CTL_UNMASK];
            end
        end
    end

    // only a change of the held bit makes an event; a repeated level is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_tgl  <= '0;
            off_tgl <= '0;
            for (int i = 0; i < NCH; i++) begin
                launch_dly[i] <= 3'h0;
            end
        end else if (wr && ch_hit && ofs == OFS_CTL) begin
            if (pwdata[CTL_ON] && !cfg[ch].on) begin
                on_tgl[ch]     <= ~on_tgl[ch]; // RULE6 RULE17
                launch_dly[ch] <= pwdata[CTL_DLY +: 3];
            end else if (!pwdata[CTL_ON] && cfg[ch].on) begin
                off_tgl[ch] <= ~off_tgl[ch]; // RULE6 RULE17
            end
        end
    end

    // outputs: code follows the pin for bucks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                level_code[i] <= DEF_CODE[i];
                level_mv[i]   <= code_to_mv(DEF_CODE[i]);
            end
            fpwm_mode         <= '0;
            low_quiescent_bit <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (i < NBUCK && pin_sync[1]) begin
                    level_code[i] <= cfg[i].alt; // RULE2 RULE3
                    level_mv[i]   <= code_to_mv(cfg[i].alt);
                end else begin
                    level_code[i] <= cfg[i].pri;
                    level_mv[i]   <= code_to_mv(cfg[i].pri);
                end
            end
            for (int i = 0; i < NBUCK; i++) begin
                fpwm_mode[i] <= cfg[i].mode; // RULE9
            end
            for (int i = 0; i < NLIN; i++) begin
                low_quiescent_bit[i] <= cfg[NBUCK+i].mode; // RULE15
            end
        end
    end

    // fault: set wins; clear needs recovery plus a status read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault     <= '0;
            read_seen <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (cfg[i].unmask && on_s[i] && !ok_s[i]) begin
                    fault[i] <= 1'b1; // RULE12
                end else if ((read_seen[i] || stat_rd) && (!on_s[i] || ok_s[i])) begin
                    fault[i] <= 1'b0; // RULE13 RULE18
                end
                if (!fault[i]) begin
                    read_seen[i] <= 1'b0;
                end else if (stat_rd) begin
                    read_seen[i] <= 1'b1; // RULE18
                end
            end
        end
    end

    assign interrupt_request_n = ~(|fault); // RULE12

    // ---- link side: delay sequencer on seq_clk ----
    logic [NCH-1:0] on_m;
    logic [NCH-1:0] on_q;
    logic [NCH-1:0] on_d;
    logic [NCH-1:0] off_m;
    logic [NCH-1:0] off_q;
    logic [NCH-1:0] off_d;
    logic [NLIN-1:0] pd_m;
    logic [NLIN-1:0] pd_q;
    rcl_lk_e        lk [NCH];
    logic [7:0]     cnt [NCH];

    always_ff @(posedge seq_clk or negedge seq_rst_n) begin
        if (!seq_rst_n) begin
            on_m  <= '0;
            on_q  <= '0;
            on_d  <= '0;
            off_m <= '0;
            off_q <= '0;
            off_d <= '0;
            pd_m  <= '0;
            pd_q  <= '0;
        end else begin
            on_m  <= on_tgl;
            on_q  <= on_m;
            on_d  <= on_q;
            off_m <= off_tgl;
            off_q <= off_m;
            off_d <= off_q;
            for (int i = 0; i < NLIN; i++) begin
                pd_m[i] <= cfg[NBUCK+i].pd;
            end
            pd_q <= pd_m;
        end
    end

    // launch_dly is stable from the toggle until the next on event
    always_ff @(posedge seq_clk or negedge seq_rst_n) begin
        if (!seq_rst_n) begin
            for (int i = 0; i < NCH; i++) begin
                lk[i]  <= LK_OFF;
                cnt[i] <= 8'h00;
            end
            supply_channel_on <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (off_q[i] != off_d[i]) begin
                    lk[i]                <= LK_OFF;
                    supply_channel_on[i] <= 1'b0; // RULE6
                end else if (on_q[i] != on_d[i]) begin
                    lk[i]  <= LK_WAIT;
                    cnt[i] <= 8'(launch_dly[i] * DELAY_STEP_CYC); // RULE8
                end else begin
                    case (lk[i])
                        LK_WAIT: begin
                            if (cnt[i] == 8'h00) begin
                                lk[i]                <= LK_ON;
                                supply_channel_on[i] <= 1'b1; // RULE8
                            end else begin
                                cnt[i] <= cnt[i] - 8'h01;
                            end
                        end
                        LK_ON:   lk[i] <= LK_ON;
                        default: lk[i] <= LK_OFF;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge seq_clk or negedge seq_rst_n) begin
        if (!seq_rst_n) begin
            pulldown_enable <= '0;
        end else begin
            pulldown_enable <= pd_q & ~supply_channel_on[NCH-1:NBUCK]; // RULE14
        end
    end

    // ---- checks ----
    sequence s_on_write(int c);
        wr && ch_hit && ofs == OFS_CTL && ch == 3'(c) && pwdata[CTL_ON] && !cfg[c].on;
    endsequence
    sequence s_stat_read;
        stat_rd;
    endsequence

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        a_on_toggle: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
            s_on_write(g) |=> on_tgl[g] != $past(on_tgl[g]))
            else $error("on write did not toggle event");
        a_level_static: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
            (wr && ofs == OFS_CTL && ch == 3'(g) && pwdata[CTL_ON] == cfg[g].on)
            |=> $stable(on_tgl[g]) && $stable(off_tgl[g]))
            else $error("static level made an event");
        a_fault_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
            cfg[g].unmask && on_s[g] && !ok_s[g] |=> fault[g] ##0 !interrupt_request_n)
            else $error("unmasked fault not raised");
        a_fault_unread: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
            fault[g] && !read_seen[g] && !stat_rd |=> fault[g])
            else $error("fault cleared without read");
        a_fault_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
            s_stat_read ##0 fault[g] ##1 (ok_s[g] || !on_s[g]) |=> !fault[g])
            else $error("fault not cleared after recovery and read");
        a_delay_wait: assert property (@(posedge seq_clk) disable iff (!seq_rst_n) // RULE8
            lk[g] == LK_WAIT && cnt[g] == 8'h02 && on_q[g] == on_d[g] && off_q[g] == off_d[g]
            ##1 (on_q[g] == on_d[g] && off_q[g] == off_d[g])[*2] |=> supply_channel_on[g])
            else $error("channel not on after delay");
    end

    a_buck_select: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        pin_sync[1] |=> level_code[0] == $past(cfg[0].alt))
        else $error("buck did not follow select pin");
    a_code_volts: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        level_code[0] == 6'h3f |-> level_mv[0] == 12'd3900)
        else $error("top code not 3.9 V");
    a_pulldown_off: assert property (@(posedge seq_clk) disable iff (!seq_rst_n) // RULE14
        supply_channel_on[NBUCK] |=> !pulldown_enable[0])
        else $error("pulldown while channel on");
endmodule : rcl_regulator_ctrl
`default_nettype wire

// ---- verif/rcl_supply_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// far side: each output settles in regulation one link clock after its
// channel turns on, unless the bench injects a fault on it
module rcl_supply_model
    import rcl_pkg::*;
(
    input  wire logic           seq_clk,
    input  wire logic           seq_rst_n,
    input  wire logic [NCH-1:0] supply_channel_on,
    input  wire logic [NCH-1:0] fault_inject,
    output logic      [NCH-1:0] power_ok_in
);
    always_ff @(posedge seq_clk or negedge seq_rst_n) begin
        if (!seq_rst_n) begin
            power_ok_in <= '0;
        end else begin
            power_ok_in <= supply_channel_on & ~fault_inject;
        end
    end
endmodule : rcl_supply_model
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rcl_pkg::*;
    logic                 pclk = 0, presetn = 0, seq_clk = 0, seq_rst_n = 0;
    logic                 psel = 0, penable = 0, pwrite = 0, voltage_choice_pin = 0;
    logic [7:0]           paddr = 8'h00;
    logic [31:0]          pwdata = 32'h0, prdata, rd;
    logic                 pready, pslverr, err, interrupt_request_n;
    logic [NCH-1:0]       power_ok_in, supply_channel_on, fault_inject = '0;
    logic [NLIN-1:0]      pulldown_enable, low_quiescent_bit;
    logic [NCH-1:0][5:0]  level_code;
    logic [NCH-1:0][11:0] level_mv;
    logic [NBUCK-1:0]     fpwm_mode;
    int                   n_mismatch = 0, n_tests = 0, cyc = 0;

    always #12.5 pclk = ~pclk;
    initial begin
        #7;
        forever #80 seq_clk = ~seq_clk;
    end

    rcl_regulator_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .seq_clk(seq_clk), .seq_rst_n(seq_rst_n),
        .voltage_choice_pin(voltage_choice_pin), .power_ok_in(power_ok_in),
        .supply_channel_on(supply_channel_on), .pulldown_enable(pulldown_enable),
        .level_code(level_code), .level_mv(level_mv), .fpwm_mode(fpwm_mode),
        .low_quiescent_bit(low_quiescent_bit), .interrupt_request_n(interrupt_request_n));
    rcl_supply_model PM (.seq_clk(seq_clk), .seq_rst_n(seq_rst_n),
        .supply_channel_on(supply_channel_on), .fault_inject(fault_inject),
        .power_ok_in(power_ok_in));

    task final_report();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            final_report();
        end
    end

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // request held until pready is seen high at a rising edge
    task apb(input logic w, input int c, input logic [7:0] ofs, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 8'(c << CH_LSB) | ofs;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] ctlw(logic on, logic [2:0] dly, logic md, logic pd, logic um);
        return 32'({um, pd, md, dly, on});
    endfunction : ctlw

    // row steps of the code table: 25 mV, 50 mV, 100 mV by column group
    function automatic logic [31:0] mv_of(logic [5:0] code);
        int base[8] = '{600, 800, 1000, 1200, 1600, 2000, 2400, 3200};
        int step[8] = '{25, 25, 25, 50, 50, 50, 100, 100};
        return 32'(base[code[2:0]] + code[5:3] * step[code[2:0]]);
    endfunction : mv_of

    task wait_on(input int c, input logic v);
        int k;
        k = 0;
        while (supply_channel_on[c] !== v && k < 100) begin
            @(posedge seq_clk);
            k++;
        end
        chk("channel on", 32'(v), 32'(supply_channel_on[c]));
    endtask : wait_on

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        seq_rst_n <= 1'b1;
        for (int c = 0; c < NCH; c++) chk("default code", 32'(DEF_CODE[c]), 32'(level_code[c]));
        chk("irq idle", 32'h1, 32'(interrupt_request_n));
        $display("test defaults done");

        apb(1, 0, OFS_PRI, 32'h0b);
        apb(1, 0, OFS_ALT, 32'h3f);
        for (int p = 0; p < 3; p++) begin
            voltage_choice_pin <= p[0];
            repeat (5) @(posedge pclk);
            chk("buck code", p[0] ? 32'h3f : 32'h0b, 32'(level_code[0]));
            chk("buck mv", mv_of(p[0] ? 6'h3f : 6'h0b), 32'(level_mv[0]));
        end
        $display("test select done");

        apb(1, 3, OFS_ALT, 32'h3f);
        chk("linear alt refused", 32'h1, 32'(err));
        apb(1, 3, OFS_PRI, 32'h00);
        voltage_choice_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("linear code", 32'h0, 32'(level_code[3]));
        chk("linear mv", 32'd600, 32'(level_mv[3]));
        voltage_choice_pin <= 1'b0;
        apb(0, 0, 8'h0c, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        $display("test linear done");

        apb(1, 3, OFS_CTL, ctlw(0, 0, 1, 1, 0));
        repeat (6) @(posedge seq_clk);
        chk("pulldown off ch", 32'h1, 32'(pulldown_enable[0]));
        chk("low q", 32'h1, 32'(low_quiescent_bit[0]));
        apb(1, 3, OFS_CTL, ctlw(1, 2, 1, 1, 0));
        repeat (12) @(posedge seq_clk);
        chk("delayed on", 32'h0, 32'(supply_channel_on[3]));
        wait_on(3, 1);
        repeat (4) @(posedge seq_clk);
        chk("pulldown on ch", 32'h0, 32'(pulldown_enable[0]));
        apb(0, 0, OFS_STAT, 32'h0);
        chk("status on ok", 32'h1, 32'(rd[ST_ON+3] & rd[ST_OK+3]));
        apb(1, 3, OFS_CTL, ctlw(0, 2, 1, 1, 0));
        wait_on(3, 0);
        apb(1, 3, OFS_CTL, ctlw(0, 2, 1, 1, 0));
        repeat (30) @(posedge seq_clk);
        chk("static level", 32'h0, 32'(supply_channel_on[3]));
        $display("test enable done");

        // unmask only once in regulation: a rising output is not a drop
        apb(1, 0, OFS_CTL, ctlw(1, 0, 1, 0, 0));
        wait_on(0, 1);
        repeat (4) @(posedge seq_clk);
        apb(1, 0, OFS_CTL, ctlw(1, 0, 1, 0, 1));
        chk("fpwm", 32'h1, 32'(fpwm_mode[0]));
        chk("irq ok", 32'h1, 32'(interrupt_request_n));
        fault_inject <= 7'h01;
        repeat (6) @(posedge seq_clk);
        chk("irq fault", 32'h0, 32'(interrupt_request_n));
        apb(0, 0, OFS_STAT, 32'h0);
        chk("status fault", 32'h1, 32'(rd[ST_FLT] & ~rd[ST_OK]));
        repeat (4) @(posedge pclk);
        chk("irq held", 32'h0, 32'(interrupt_request_n));
        fault_inject <= 7'h00;
        repeat (6) @(posedge seq_clk);
        apb(0, 0, OFS_STAT, 32'h0);
        repeat (4) @(posedge pclk);
        chk("irq cleared", 32'h1, 32'(interrupt_request_n));
        apb(1, 4, OFS_CTL, ctlw(1, 0, 0, 0, 0));
        wait_on(4, 1);
        repeat (4) @(posedge seq_clk);
        apb(1, 4, OFS_CTL, ctlw(1, 0, 0, 0, 1));
        fault_inject <= 7'h10;
        repeat (6) @(posedge seq_clk);
        chk("irq linear", 32'h0, 32'(interrupt_request_n));
        apb(1, 4, OFS_CTL, ctlw(0, 0, 0, 0, 1));
        wait_on(4, 0);
        repeat (6) @(posedge seq_clk);
        chk("irq unread", 32'h0, 32'(interrupt_request_n));
        apb(0, 0, OFS_STAT, 32'h0);
        repeat (4) @(posedge pclk);
        chk("irq off read", 32'h1, 32'(interrupt_request_n));
        $display("test fault done");
        final_report();
    end
endmodule : tb
`default_nettype wire
